// *** hdl/dacc_mac_unit.sv ***
/*
 * Accumulator pair and multiply-accumulate datapath, memory mapped parts.
 * Assumes a decoded command each cycle, combinational X/Y read data in the
 * same cycle as the read strobe, and register files that take the writes.
 */
// Operation
// - two 40-bit accumulators, guard:high:low
// - load fills high, zero low, sign guard
// - stores take the high word
// - normal saturation: guard only sign extends
// - super or no saturation: all 40 bits
// - six parts memory mapped, readable, writable
// - guard reads sign extended, byte or word
// - plain writes never touch flags
// - MAC result in one cycle, prefetch dest a cycle later
// - X uses 8/9, Y 10/11, dest 4-7
// - offset mode adds offset register, 9/11
// - pointer steps even, up to three words
// - offset mode updates no pointer
// - operands any of 4-7, same squares
// - distance writes difference, not prefetches
// - clear zeroes, move-and-store no multiply
// - write back rounded other accumulator via 13
// - write back only on four op kinds
// - target implied, indirect pointer plus 2
// - control bit 4 selects guard saturation
// - fractional product shifted left one
`include "dacc_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module dacc_mac_unit (
	input wire logic clock_in, // core clock
	input wire logic rstn_in, // async reset, low
	input wire logic [15:0] core_control_in, // core control register
	input wire logic cmd_valid_in, // command this cycle
	input wire dacc_pkg::dacc_cmd_type cmd_in, // decoded command
	input wire logic [15:0] x_rdata_in, // X bus read data
	input wire logic [15:0] y_rdata_in, // Y bus read data
	input wire logic [15:0] sfr_addr_in, // register address
	input wire logic sfr_we_in, // register write
	input wire logic [1:0] sfr_be_in, // byte lanes
	input wire logic [15:0] sfr_wdata_in, // register write data
	output logic [15:0] sfr_rdata_out, // register read data
	output dacc_pkg::dacc_mem_type x_rd_out, // X prefetch read
	output dacc_pkg::dacc_mem_type y_rd_out, // Y prefetch read
	output dacc_pkg::dacc_wwr_type x_dest_out, // X prefetch dest write
	output dacc_pkg::dacc_wwr_type y_dest_out, // Y prefetch dest write
	output dacc_pkg::dacc_wwr_type x_ptr_out, // X pointer update
	output dacc_pkg::dacc_wwr_type y_ptr_out, // Y pointer update
	output dacc_pkg::dacc_wwr_type wb_reg_out, // write back register write
	output dacc_pkg::dacc_mem_type wb_mem_out, // write back memory store
	output dacc_pkg::dacc_mem_type store_out, // accumulator store data
	output dacc_pkg::dacc_flags_type flags_out // overflow, saturation
);
	// ==========================================
	// state
	// guard:high:low
	logic [39:0] acc [2]; // the accumulator pair
	logic [39:0] next_acc [2];
	logic [1:0] ov, next_ov; // overflow per accumulator
	logic [1:0] sat, next_sat; // saturation per accumulator
	logic [15:0] next_rdata;
	dacc_pkg::dacc_mem_type next_wb_mem, next_store;
	dacc_pkg::dacc_wwr_type next_wb_reg;
	logic frac, sat_en, super_sat; // control bits
	logic arith, wb_ok; // op class
	logic sel; // target accumulator
	logic [39:0] other; // alternate accumulator
	logic [15:0] rounded; // rounded high word of a source
	logic signed [31:0] prod_raw;
	logic [39:0] prod40, res40;
	logic [40:0] sum41;
	logic res_sat;
	assign super_sat = core_control_in[`DACC_CC_SATSEL_BIT];
	assign sat_en = core_control_in[`DACC_CC_SATEN_BIT];
	assign frac = ~core_control_in[`DACC_CC_FRAC_N_BIT];
	assign sel = cmd_in.acc_sel;
	assign other = acc[~sel];
	// ==========================================
	// arithmetic path
	always_comb begin
		prod_raw = $signed(cmd_in.a_val) * $signed(cmd_in.b_val);
		if (frac) begin
			prod40 = {{7{prod_raw[31]}}, prod_raw, 1'b0};
		end else begin
			prod40 = {{8{prod_raw[31]}}, prod_raw};
		end
		arith = 1'b1;
		unique case (cmd_in.op)
			dacc_pkg::OP_MAC, dacc_pkg::OP_DISTANCE_ACCUMULATE_OP: begin
				sum41 = {acc[sel][39], acc[sel]} + {prod40[39], prod40};
			end
			dacc_pkg::OP_MSC: begin
				sum41 = {acc[sel][39], acc[sel]} - {prod40[39], prod40};
			end
			dacc_pkg::OP_MPY, dacc_pkg::OP_ED: begin
				sum41 = {prod40[39], prod40};
			end
			dacc_pkg::OP_MPYN: begin
				sum41 = 41'h00000000000 - {prod40[39], prod40};
			end
			dacc_pkg::OP_CLR: begin
				sum41 = 41'h00000000000;
			end
			default: begin
				sum41 = 41'h00000000000;
				arith = 1'b0;
			end
		endcase
		res_sat = 1'b0;
		res40 = sum41[39:0];
		if (sat_en && super_sat) begin
			// full width, clip at 40 bits
			if (sum41[40] != sum41[39]) begin
				res40 = sum41[40] ? `DACC_NEG_MIN40 : `DACC_POS_MAX40;
				res_sat = 1'b1;
			end
		end else if (sat_en) begin
			// clip to 32 bits, guard only sign
			if (!(&sum41[40:31] || ~|sum41[40:31])) begin
				res40 = sum41[40] ? `DACC_NEG_MIN32 : `DACC_POS_MAX32;
				res_sat = 1'b1;
			end
		end
	end
	// ==========================================
	// accumulators, flags, register port
	always_comb begin
		next_acc = acc;
		next_ov = ov;
		next_sat = sat;
		next_rdata = 16'h0000;
		// file register access to each part
		for (int i = 0; i < 2; i++) begin
			logic [15:0] base;
			base = (i == 0) ? `DACC_OFS_A_BASE : `DACC_OFS_B_BASE;
			if (sfr_addr_in == base + `DACC_PART_LOW) begin
				next_rdata = acc[i][15:0];
				if (sfr_we_in && sfr_be_in[0]) next_acc[i][7:0] = sfr_wdata_in[7:0];
				if (sfr_we_in && sfr_be_in[1]) next_acc[i][15:8] = sfr_wdata_in[15:8];
			end
			if (sfr_addr_in == base + `DACC_PART_HIGH) begin
				next_rdata = acc[i][31:16];
				if (sfr_we_in && sfr_be_in[0]) next_acc[i][23:16] = sfr_wdata_in[7:0];
				if (sfr_we_in && sfr_be_in[1]) next_acc[i][31:24] = sfr_wdata_in[15:8];
			end
			// guard seen as a signed word
			if (sfr_addr_in == base + `DACC_PART_GUARD) begin
				next_rdata = {{8{acc[i][39]}}, acc[i][39:32]};
				if (sfr_we_in && sfr_be_in[0]) next_acc[i][39:32] = sfr_wdata_in[7:0];
			end
		end
		// flags move only below, never on writes
		// an op on the same accumulator outranks a register write
		if (cmd_valid_in && arith) begin
			next_acc[sel] = res40;
			next_ov[sel] = !(&res40[39:31] || ~|res40[39:31]);
			next_sat[sel] = res_sat;
		end else if (cmd_valid_in && cmd_in.op == dacc_pkg::OP_LAC) begin
			next_acc[sel] = {{8{cmd_in.load_word[15]}}, cmd_in.load_word, 16'h0000};
		end
	end
	// ==========================================
	// stores and write back
	always_comb begin
		// round to nearest by the top bit of the low word
		rounded = acc[sel][31:16] + {15'h0000, acc[sel][15]};
		next_store = '0;
		if (cmd_valid_in && cmd_in.op == dacc_pkg::OP_SAC) begin
			next_store = '{en: 1'b1, addr: 16'h0000, data: acc[sel][31:16]};
		end else if (cmd_valid_in && cmd_in.op == dacc_pkg::OP_SACR) begin
			next_store = '{en: 1'b1, addr: 16'h0000, data: rounded};
		end
		// only four kinds may write back
		unique case (cmd_in.op)
			dacc_pkg::OP_CLR, dacc_pkg::OP_MOVE_AND_STORE_OP, dacc_pkg::OP_MSC: wb_ok = 1'b1;
			dacc_pkg::OP_MAC: wb_ok = !cmd_in.same_reg;
			default: wb_ok = 1'b0;
		endcase
		next_wb_mem = '0;
		next_wb_reg = '0;
		if (cmd_valid_in && wb_ok && cmd_in.wb == dacc_pkg::WB_DIRECT) begin
			next_wb_reg = '{we: 1'b1, idx: `DACC_W_WBPTR,
				data: other[31:16] + {15'h0000, other[15]}};
		end else if (cmd_valid_in && wb_ok && cmd_in.wb == dacc_pkg::WB_INDIRECT) begin
			next_wb_mem = '{en: 1'b1, addr: cmd_in.wb_ptr,
				data: other[31:16] + {15'h0000, other[15]}};
			next_wb_reg = '{we: 1'b1, idx: `DACC_W_WBPTR,
				data: cmd_in.wb_ptr + `DACC_WB_STEP};
		end
	end
	// accumulators and result registers
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			acc[0] <= `DACC_ACC_RESET;
			acc[1] <= `DACC_ACC_RESET;
			ov <= 2'h0;
			sat <= 2'h0;
			sfr_rdata_out <= 16'h0000;
			store_out <= '0;
			wb_mem_out <= '0;
			wb_reg_out <= '0;
		end else begin
			acc <= next_acc;
			ov <= next_ov;
			sat <= next_sat;
			sfr_rdata_out <= next_rdata;
			store_out <= next_store;
			wb_mem_out <= next_wb_mem;
			wb_reg_out <= next_wb_reg;
		end
	end
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flags_out <= '0;
		end else begin
			flags_out <= '{ov_first: next_ov[0], ov_second: next_ov[1],
				sat_first: next_sat[0], sat_second: next_sat[1]};
		end
	end
	// ==========================================
	// prefetch channels, X then Y
	dacc_pkg::dacc_pf_type pf [2];
	dacc_pkg::dacc_mem_type rd [2];
	dacc_pkg::dacc_wwr_type ptrw [2], dest [2];
	logic [15:0] rdata [2];
	logic is_dist; // distance op in the pending prefetch
	logic next_is_dist;
	assign pf[0] = cmd_in.x_pf;
	assign pf[1] = cmd_in.y_pf;
	assign rdata[0] = x_rdata_in;
	assign rdata[1] = y_rdata_in;
	assign next_is_dist = cmd_valid_in &&
		(cmd_in.op == dacc_pkg::OP_ED || cmd_in.op == dacc_pkg::OP_DISTANCE_ACCUMULATE_OP);
	for (genvar c = 0; c < 2; c++) begin : g_pf
		dacc_pkg::dacc_mem_type next_rd;
		dacc_pkg::dacc_wwr_type next_ptrw, next_dest;
		logic [1:0] pend_dest, next_pend_dest; // destination of the read
		logic [15:0] delta;
		logic use_ofs;
		always_comb begin
			// signed word step, doubled to bytes
			delta = {{12{pf[c].step[2]}}, pf[c].step, 1'b0};
			// offset only with the second pointer
			use_ofs = pf[c].offset_mode && pf[c].sel;
			next_rd = '0;
			next_ptrw = '0;
			next_pend_dest = pf[c].dest;
			// both reads go out the cycle after the command
			if (cmd_valid_in && pf[c].en && cmd_in.op != dacc_pkg::OP_LAC
					&& cmd_in.op != dacc_pkg::OP_SAC && cmd_in.op != dacc_pkg::OP_SACR) begin
				next_rd.en = 1'b1;
				next_rd.addr = use_ofs ? pf[c].ptr + cmd_in.offset : pf[c].ptr;
				if (!use_ofs && pf[c].step != 3'h0 && pf[c].step != `DACC_STEP_ILLEGAL) begin
					next_ptrw = '{we: 1'b1,
						idx: ((c == 0) ? `DACC_W_XPTR0 : `DACC_W_YPTR0) + {3'h0, pf[c].sel},
						data: pf[c].ptr + delta};
				end
			end
			next_dest = '0;
			if (rd[c].en) begin
				// distance writes X minus Y on X only
				if (is_dist) begin
					next_dest = '{we: (c == 0), idx: `DACC_W_DEST0 + {2'h0, pend_dest},
						data: rdata[0] - rdata[1]};
				end else begin
					next_dest = '{we: 1'b1, idx: `DACC_W_DEST0 + {2'h0, pend_dest},
						data: rdata[c]};
				end
			end
		end
		always_ff @(posedge clock_in or negedge rstn_in) begin
			if (!rstn_in) begin
				rd[c] <= '0;
				ptrw[c] <= '0;
				dest[c] <= '0;
				pend_dest <= 2'h0;
			end else begin
				rd[c] <= next_rd;
				ptrw[c] <= next_ptrw;
				dest[c] <= next_dest;
				pend_dest <= next_pend_dest;
			end
		end
	end
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			is_dist <= 1'b0;
		end else begin
			is_dist <= next_is_dist;
		end
	end
	// outputs straight from the channel flops
	assign x_rd_out = rd[0];
	assign y_rd_out = rd[1];
	assign x_ptr_out = ptrw[0];
	assign y_ptr_out = ptrw[1];
	assign x_dest_out = dest[0];
	assign y_dest_out = dest[1];
	// ==========================================
	// checks
	default clocking @(posedge clock_in); endclocking
	default disable iff (!rstn_in);
	sequence load_cmd_s;
		cmd_valid_in && cmd_in.op == dacc_pkg::OP_LAC;
	endsequence
	sequence ed_read_s;
		cmd_valid_in && next_is_dist && cmd_in.x_pf.en;
	endsequence
	load_fill_a: assert property (load_cmd_s |=>
		acc[$past(sel)] == {{8{$past(cmd_in.load_word[15])}},
		$past(cmd_in.load_word), 16'h0000}) else $error("load fill wrong");
	store_high_a: assert property (cmd_valid_in && cmd_in.op == dacc_pkg::OP_SAC
		|=> store_out.en && store_out.data == $past(acc[sel][31:16]))
		else $error("store not from high word");
	norm_guard_a: assert property (cmd_valid_in && arith && sat_en && !super_sat
		|=> (&acc[$past(sel)][39:31] || ~|acc[$past(sel)][39:31]))
		else $error("guard not sign only");
	mov_noflag_a: assert property (!cmd_valid_in |=> $stable(flags_out))
		else $error("flag moved without op");
	ofs_noupd_a: assert property (cmd_valid_in && cmd_in.x_pf.en && cmd_in.x_pf.offset_mode
		&& cmd_in.x_pf.sel && cmd_in.op == dacc_pkg::OP_MAC |=> !x_ptr_out.we)
		else $error("pointer moved in offset mode");
	ptr_step_a: assert property (x_ptr_out.we |->
		x_ptr_out.data - $past(cmd_in.x_pf.ptr) inside {16'hFFFA, 16'hFFFC,
		16'hFFFE, 16'h0002, 16'h0004, 16'h0006}) else $error("bad pointer step");
	ed_diff_a: assert property (ed_read_s ##1 1'b1 |=>
		x_dest_out.we && !y_dest_out.we
		&& x_dest_out.data == $past(x_rdata_in) - $past(y_rdata_in))
		else $error("distance dest wrong");
	wb_block_a: assert property (cmd_valid_in && (cmd_in.op == dacc_pkg::OP_MPY
		|| cmd_in.op == dacc_pkg::OP_ED) |=> !wb_reg_out.we && !wb_mem_out.en)
		else $error("write back on barred op");
	wb_inc_a: assert property (wb_mem_out.en |-> wb_reg_out.we
		&& wb_reg_out.data == wb_mem_out.addr + 16'h0002) else $error("wb pointer step");
	clr_zero_a: assert property (cmd_valid_in && cmd_in.op == dacc_pkg::OP_CLR
		|=> acc[$past(sel)] == 40'h0000000000) else $error("clear not zero");
endmodule : dacc_mac_unit
`default_nettype wire

// *** hdl/dacc_regs.svh ***
/*
 * Offsets, field positions, reset values and limits of the accumulator unit.
 * Assumes it is included by bare name from the unit.
 */
`ifndef DACC_REGS_SVH
`define DACC_REGS_SVH
// ==========================================
// memory mapped accumulator parts
`define DACC_OFS_A_BASE 16'h0022
`define DACC_OFS_B_BASE 16'h0028
`define DACC_PART_LOW 16'h0000
`define DACC_PART_HIGH 16'h0002
`define DACC_PART_GUARD 16'h0004
// ==========================================
// core control bits
`define DACC_CC_FRAC_N_BIT 0
`define DACC_CC_SATSEL_BIT 4
`define DACC_CC_SATEN_BIT 7
// ==========================================
// values and steps
`define DACC_ACC_RESET 40'h0000000000
`define DACC_POS_MAX32 40'h007FFFFFFF
`define DACC_NEG_MIN32 40'hFF80000000
`define DACC_POS_MAX40 40'h7FFFFFFFFF
`define DACC_NEG_MIN40 40'h8000000000
`define DACC_WB_STEP 16'h0002
`define DACC_STEP_ILLEGAL 3'h4
`define DACC_W_DEST0 4'h4
`define DACC_W_XPTR0 4'h8
`define DACC_W_YPTR0 4'hA
`define DACC_W_WBPTR 4'hD
`endif

// *** hdl/dacc_pkg.sv ***
/*
 * Types of the accumulator and multiply-accumulate unit.
 * Assumes the core decoder fills the command struct.
 */
`default_nettype none
package dacc_pkg;
	// ==========================================
	// operations
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_CLR = 4'h1, OP_ED = 4'h2, OP_DISTANCE_ACCUMULATE_OP = 4'h3,
		OP_MAC = 4'h4, OP_MOVE_AND_STORE_OP = 4'h5, OP_MPY = 4'h6, OP_MPYN = 4'h7,
		OP_MSC = 4'h8, OP_LAC = 4'h9, OP_SAC = 4'hA, OP_SACR = 4'hB
	} dacc_op_type;
	typedef enum logic [1:0] {
		WB_NONE = 2'h0, WB_DIRECT = 2'h1, WB_INDIRECT = 2'h2
	} dacc_wb_type;
	// ==========================================
	// one prefetch: enable, pointer pick, offset mode, step in words
	typedef struct packed {
		logic en;
		logic sel;
		logic offset_mode;
		logic [2:0] step;
		logic [1:0] dest;
		logic [15:0] ptr;
	} dacc_pf_type;
	typedef struct packed {
		dacc_op_type op;
		logic acc_sel;
		logic [15:0] a_val;
		logic [15:0] b_val;
		logic same_reg;
		logic [15:0] offset;
		dacc_pf_type x_pf;
		dacc_pf_type y_pf;
		dacc_wb_type wb;
		logic [15:0] wb_ptr;
		logic [15:0] load_word;
	} dacc_cmd_type;
	// working register write and data memory access
	typedef struct packed {
		logic we;
		logic [3:0] idx;
		logic [15:0] data;
	} dacc_wwr_type;
	typedef struct packed {
		logic en;
		logic [15:0] addr;
		logic [15:0] data;
	} dacc_mem_type;
	typedef struct packed {
		logic ov_first;
		logic ov_second;
		logic sat_first;
		logic sat_second;
	} dacc_flags_type;
endpackage : dacc_pkg
`default_nettype wire

// *** verif/dacc_mem_model.sv ***
/* Behavioural X and Y data memory facing the accumulator unit.
 * Assumes one read strobe per bus per cycle, answered within that cycle. */
`timescale 1ns/100ps
`default_nettype none
module dacc_mem_model #(
	parameter logic [15:0] X_OFS = 16'h1000, // x word: address plus this
	parameter logic [15:0] Y_OFS = 16'h0010 // y word: address plus this
) (
	input wire logic clock_in, // core clock
	input wire logic rstn_in, // async reset, low
	input wire dacc_pkg::dacc_mem_type x_rd_in, // x read strobe
	input wire dacc_pkg::dacc_mem_type y_rd_in, // y read strobe
	output logic [15:0] x_rdata_out, // x read data
	output logic [15:0] y_rdata_out // y read data
);
	// ==========================================
	// read data
	logic [15:0] x_last; // last x word shown
	logic [15:0] y_last; // last y word shown
	always_comb begin
		// an idle bus shows the inverse, so a stale word is never taken
		x_rdata_out = x_rd_in.en ? x_rd_in.addr + X_OFS : ~x_last;
		y_rdata_out = y_rd_in.en ? y_rd_in.addr + Y_OFS : ~y_last;
	end
	// remember what each bus showed
	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			x_last <= 16'h0000;
			y_last <= 16'h0000;
		end else begin
			x_last <= x_rdata_out;
			y_last <= y_rdata_out;
		end
	end
endmodule : dacc_mem_model
`default_nettype wire

// *** verif/test_dsp_accumulator_mac_unit.sv ***
/* Self-checking bench: register port, load/store, prefetch, write back.
 * Assumes the memory model stands on the X and Y buses. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
	$display("Error %0t: got %h want %h", $time, g, e); end end
module test_dsp_accumulator_mac_unit;
	// ==========================================
	// signals
	logic clock_in, rstn_in, cv, swe; // clock, reset, strobes
	logic [15:0] cc, xr, yr, sa, swd, rd; // control, data, register port
	logic [1:0] sbe; // byte lanes
	dacc_pkg::dacc_cmd_type cmd; // decoded command
	dacc_pkg::dacc_mem_type xro, yro, wm, st; // memory side
	dacc_pkg::dacc_wwr_type xd, yd, xp, yp, wr; // register writes
	dacc_pkg::dacc_flags_type fl; // flags
	int errors, checks, cycles, i; // counters
	dacc_pkg::dacc_op_type nw [4] = '{dacc_pkg::OP_MPY, dacc_pkg::OP_MPYN,
		dacc_pkg::OP_ED, dacc_pkg::OP_DISTANCE_ACCUMULATE_OP}; // no write back
	dacc_pkg::dacc_op_type yw [4] = '{dacc_pkg::OP_CLR, dacc_pkg::OP_MOVE_AND_STORE_OP,
		dacc_pkg::OP_MSC, dacc_pkg::OP_MAC}; // write back allowed
	logic [15:0] md [3] = '{16'h0000, 16'h0090, 16'h0080}; // saturation modes
	dacc_mac_unit DUT (.clock_in(clock_in), .rstn_in(rstn_in), .core_control_in(cc),
		.cmd_valid_in(cv), .cmd_in(cmd), .x_rdata_in(xr), .y_rdata_in(yr),
		.sfr_addr_in(sa), .sfr_we_in(swe), .sfr_be_in(sbe), .sfr_wdata_in(swd),
		.sfr_rdata_out(rd), .x_rd_out(xro), .y_rd_out(yro), .x_dest_out(xd),
		.y_dest_out(yd), .x_ptr_out(xp), .y_ptr_out(yp), .wb_reg_out(wr),
		.wb_mem_out(wm), .store_out(st), .flags_out(fl));
	dacc_mem_model MEM (.clock_in(clock_in), .rstn_in(rstn_in), .x_rd_in(xro),
		.y_rd_in(yro), .x_rdata_out(xr), .y_rdata_out(yr));
	// ==========================================
	// clock and hang guard
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end
	// a run should end well inside this many cycles
	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			close_out;
		end
	end
	// ==========================================
	// access tasks
	task tick;
		@(posedge clock_in);
		#1;
	endtask : tick
	task close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out
	// register write, lanes held one edge
	task wreg(input logic [15:0] a, input logic [1:0] be, input logic [15:0] d);
		sa = a;
		sbe = be;
		swd = d;
		swe = 1'b1;
		tick;
		swe = 1'b0;
	endtask : wreg
	// read answers one edge after the address
	task rchk(input logic [15:0] a, input logic [15:0] e);
		sa = a;
		tick;
		`CHK(rd, e)
	endtask : rchk
	task op(input dacc_pkg::dacc_op_type o, input logic s);
		cmd = '0;
		cmd.op = o;
		cmd.acc_sel = s;
	endtask : op
	// valid stays up so commands may follow back to back
	task go;
		cv = 1'b1;
		tick;
	endtask : go
	// ==========================================
	// main sequence
	initial begin
		rstn_in = 1'b0; cv = 1'b0; swe = 1'b0; sbe = 2'h0; cc = 16'h0080;
		sa = 16'h0000; swd = 16'h0000; cmd = '0; errors = 0; checks = 0; cycles = 0;
		repeat (8) @(posedge clock_in);
		#1 rstn_in = 1'b1;
		for (i = 0; i < 6; i++) rchk(16'h0022 + 16'(2 * i), 16'h0000);
		rchk(16'h0030, 16'h0000);
		wreg(16'h0022, 2'h3, 16'hBEEF);
		rchk(16'h0022, 16'hBEEF);
		wreg(16'h0026, 2'h1, 16'h0080);
		rchk(16'h0026, 16'hFF80);
		wreg(16'h0026, 2'h3, 16'h0012);
		rchk(16'h0026, 16'h0012);
		wreg(16'h0024, 2'h3, 16'h8000);
		`CHK(fl, 4'h0)
		// load sign fills guard, zeroes low
		op(dacc_pkg::OP_LAC, 1'b0);
		cmd.load_word = 16'h8001;
		go;
		cv = 1'b0;
		rchk(16'h0026, 16'hFFFF);
		rchk(16'h0024, 16'h8001);
		rchk(16'h0022, 16'h0000);
		op(dacc_pkg::OP_SAC, 1'b0);
		go;
		`CHK(st.data, 16'h8001)
		// square, fractional then integer
		op(dacc_pkg::OP_MPY, 1'b1);
		cmd.a_val = 16'h4000;
		cmd.b_val = 16'h4000;
		cmd.same_reg = 1'b1;
		go;
		cv = 1'b0;
		rchk(16'h002A, 16'h2000);
		cc = 16'h0081;
		go;
		cv = 1'b0;
		rchk(16'h002A, 16'h1000);
		// back to back ops that must not write back
		for (i = 0; i < 4; i++) begin
			op(nw[i], 1'b0);
			cmd.same_reg = 1'b1;
			cmd.wb = dacc_pkg::WB_DIRECT;
			go;
			`CHK(wr.we, 1'b0)
		end
		op(dacc_pkg::OP_MAC, 1'b0);
		cmd.same_reg = 1'b1;
		cmd.wb = dacc_pkg::WB_DIRECT;
		go;
		`CHK(wr.we, 1'b0)
		for (i = 0; i < 4; i++) begin
			op(yw[i], 1'b0);
			cmd.wb = dacc_pkg::WB_DIRECT;
			go;
			`CHK(wr, {1'b1, 4'hD, 16'h1000})
		end
		// indirect write back of the other accumulator
		op(dacc_pkg::OP_CLR, 1'b0);
		cmd.wb = dacc_pkg::WB_INDIRECT;
		cmd.wb_ptr = 16'h0800;
		go;
		cv = 1'b0;
		`CHK(wm, {1'b1, 16'h0800, 16'h1000})
		`CHK(wr.data, 16'h0802)
		rchk(16'h0024, 16'h0000);
		// prefetch step, offset mode, destinations
		op(dacc_pkg::OP_MAC, 1'b0);
		cmd.offset = 16'hFFFE;
		cmd.x_pf = {1'b1, 1'b0, 1'b0, 3'h5, 2'h2, 16'h0300};
		cmd.y_pf = {1'b1, 1'b1, 1'b1, 3'h2, 2'h3, 16'h0400};
		go;
		cv = 1'b0;
		`CHK(xro.addr, 16'h0300)
		`CHK(xp, {1'b1, 4'h8, 16'h02FA})
		`CHK(yro.addr, 16'h03FE)
		`CHK(yp.we, 1'b0)
		tick;
		`CHK(xd, {1'b1, 4'h6, 16'h1300})
		`CHK(yd, {1'b1, 4'h7, 16'h040E})
		// distance writes only the difference
		op(dacc_pkg::OP_ED, 1'b0);
		cmd.same_reg = 1'b1;
		cmd.x_pf = {1'b1, 1'b0, 1'b0, 3'h0, 2'h0, 16'h0100};
		cmd.y_pf = {1'b1, 1'b0, 1'b0, 3'h0, 2'h1, 16'h0200};
		go;
		cv = 1'b0;
		tick;
		`CHK(xd, {1'b1, 4'h4, 16'h0EF0})
		`CHK(yd.we, 1'b0)
		// rounding by the low word's top bit, offset prefetch on X
		wreg(16'h0028, 2'h3, 16'h8000);
		op(dacc_pkg::OP_SACR, 1'b1);
		go;
		cv = 1'b0;
		`CHK(st, {1'b1, 16'h0000, 16'h1001})
		op(dacc_pkg::OP_MAC, 1'b0);
		cmd.wb = dacc_pkg::WB_DIRECT;
		cmd.offset = 16'h0004;
		cmd.x_pf = {1'b1, 1'b1, 1'b1, 3'h1, 2'h1, 16'h0500};
		cmd.y_pf = {1'b1, 1'b0, 1'b0, 3'h4, 2'h0, 16'h0600};
		go;
		cv = 1'b0;
		`CHK(wr, {1'b1, 4'hD, 16'h1001})
		`CHK(xro.addr, 16'h0504)
		`CHK(xp.we, 1'b0)
		`CHK(yp.we, 1'b0)
		// clear a second accumulator that holds a value
		op(dacc_pkg::OP_CLR, 1'b1);
		go;
		cv = 1'b0;
		rchk(16'h002A, 16'h0000);
		// four squares of the largest word per saturation mode
		for (i = 0; i < 3; i++) begin
			cc = md[i];
			op(dacc_pkg::OP_CLR, 1'b0);
			go;
			op(dacc_pkg::OP_MAC, 1'b0);
			cmd.a_val = 16'h7FFF;
			cmd.b_val = 16'h7FFF;
			cmd.same_reg = 1'b1;
			repeat (4) go;
			cv = 1'b0;
			`CHK(fl.sat_first, i == 2)
			`CHK(fl.ov_first, i != 2)
			rchk(16'h0026, (i == 2) ? 16'h0000 : 16'h0001);
			rchk(16'h0024, (i == 2) ? 16'h7FFF : 16'hFFF8);
			rchk(16'h0022, (i == 2) ? 16'hFFFF : 16'h0008);
		end
		close_out;
	end
endmodule : test_dsp_accumulator_mac_unit
`default_nettype wire
